// *** rtcto_regs.vh ***
`ifndef RTCTO_REGS_VH
`define RTCTO_REGS_VH

// Register byte offsets
`define RTCTO_OFF_TIME   6'h00
`define RTCTO_OFF_DATE   6'h04
`define RTCTO_OFF_CTL    6'h08
`define RTCTO_OFF_TAMP   6'h0C
`define RTCTO_OFF_STAT   6'h10
`define RTCTO_OFF_PSC    6'h14
`define RTCTO_BKP_BIT    5

// Reset values and writable masks
`define RTCTO_TIME_RST   32'h00000000
`define RTCTO_DATE_RST   32'h00002101
`define RTCTO_TIME_MASK  32'h007F7F7F
`define RTCTO_DATE_MASK  32'h00FFFF3F
`define RTCTO_CTL_MASK   32'h00F89020
`define RTCTO_TAMP_MASK  32'h0000FF9F
`define RTCTO_PSC_RST    32'h007F00FF
`define RTCTO_PSC_MASK   32'h007F7FFF

// Control fields
`define RTCTO_CTL_CALEN  23
`define RTCTO_CTL_SRC_HI 22
`define RTCTO_CTL_SRC_LO 21
`define RTCTO_CTL_APOL   20
`define RTCTO_CTL_COS    19
`define RTCTO_CTL_TSINT  15
`define RTCTO_CTL_ALIE   12
`define RTCTO_CTL_BYPASS 5

// Tamper configuration fields
`define RTCTO_TP_EN0     0
`define RTCTO_TP_EG0     1
`define RTCTO_TP_IE      2
`define RTCTO_TP_STRIDE  3
`define RTCTO_TP_TS      7
`define RTCTO_TP_RATE_LO 8
`define RTCTO_TP_RATE_HI 10
`define RTCTO_TP_FILT_LO 11
`define RTCTO_TP_FILT_HI 12
`define RTCTO_TP_PCHG_LO 13
`define RTCTO_TP_PCHG_HI 14
`define RTCTO_TP_NOPU    15

// Status fields
`define RTCTO_ST_INIT    7
`define RTCTO_ST_ALRM    8
`define RTCTO_ST_TSFLAG  11
`define RTCTO_ST_TPF0    14

// Prescaler fields
`define RTCTO_PSC_S_HI   14
`define RTCTO_PSC_A_LO   16
`define RTCTO_PSC_A_HI   22

// Timestamp flag delay in prescaled ticks
`define RTCTO_TS_DELAY   2

`endif

// *** rtcto_top.v ***
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/10ps
`include "rtcto_regs.vh"

// Notes on behaviour
// - Any tamper event clears all backup registers
// - Backup cleared only by tamper or backup reset
// - Per-input enable; event sets its own flag
// - Shared enable gates tamper interrupt request
// - Tamper-as-timestamp also sets timestamp flag
// - Zero filter count means edge mode
// - Edge mode keeps pull-up off always
// - Nonzero filter: 2/4/8 consecutive active samples
// - Pull-up precharges before each level sample
// - Sample interval follows sample rate field
// - Calibration clock out only when enabled
// - Select clear: RTC clock divided by 64 with async prescaler 63 or 127
// - Select set: divide by both prescalers
// - Nonzero source drives alarm flag to pin
// - Polarity bit inverts alarm pin
// - Low-power wake only on slow clock sources
// - Time register BCD layout
// - Date register BCD layout
// - Weekday bits 15:13, Monday 1 to 7
// - Time/date word writes in init only
// - System reset clears time/date unless bypass
// - Timestamp flag two prescaled ticks late
module rtcto_top #(
    parameter NBKP = 5
) (
    // Clock and resets
    input  wire        i_clk,
    input  wire        i_rst_n,
    input  wire        i_bkp_rst_n,
    // Avalon-MM slave
    input  wire [5:0]  i_avs_address,
    input  wire        i_avs_read,
    input  wire        i_avs_write,
    input  wire [3:0]  i_avs_byteenable,
    input  wire [31:0] i_avs_writedata,
    output wire [31:0] o_avs_readdata,
    output wire        o_avs_waitrequest,
    // Tamper pins
    input  wire [1:0]  i_tamper_pin,
    output wire [1:0]  o_tamper_pullup,
    // Alarm flag and clock source status
    input  wire        i_alarm_zero_flag,
    input  wire        i_slow_clk_src,
    // Output pins
    output wire        o_calib_out,
    output wire        o_calib_oe,
    output wire        o_alarm_out,
    output wire        o_alarm_oe,
    // Events toward the external event controller
    output wire        o_tamper_irq,
    output wire        o_timestamp_irq,
    output wire        o_alarm_irq,
    output wire        o_wakeup
);

    reg  [31:0] time_q;
    reg  [31:0] date_q;
    reg  [31:0] ctl_q;
    reg  [31:0] tcfg_q;
    reg  [31:0] psc_q;
    reg         init_q;
    reg         tsf_q;
    reg  [1:0]  tflag_q;
    reg  [31:0] bkp_q [0:NBKP-1];
    reg         ack_q;
    reg  [31:0] rdata_q;
    reg  [31:0] rd_d;
    reg  [6:0]  apre_cnt_q;
    reg  [14:0] spre_cnt_q;
    reg  [7:0]  samp_cnt_q;
    reg  [3:0]  pch_q;
    reg  [1:0]  ts_pend_q;
    reg         calib_q;
    reg         alarm_q;

    wire [1:0]  ev;
    wire [2:0]  bkp_idx = i_avs_address[4:2];
    wire        word_acc = (i_avs_byteenable == 4'hF);
    wire        wr_go = i_avs_write & ack_q;
    wire        bkp_hit;
    wire        apre_tick;
    wire        samp_due;
    wire        samp_strobe;
    wire        level_mode;
    wire [1:0]  filt;
    wire [2:0]  rate;
    wire [1:0]  pchg;
    wire [3:0]  need;
    integer     i;

    function [31:0] rtcto_merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  be;
        integer      k;
        begin
            rtcto_merge = old_v;
            for (k = 0; k < 4; k = k + 1) begin
                if (be[k]) begin
                    rtcto_merge[8*k +: 8] = new_v[8*k +: 8];
                end
            end
        end
    endfunction

    // Bus slave: one wait cycle, answer on the second edge
    assign o_avs_waitrequest = ~ack_q;
    assign o_avs_readdata    = rdata_q;
    assign bkp_hit = i_avs_address[`RTCTO_BKP_BIT] && (i_avs_address[1:0] == 2'h0)
                     && ({29'h0, bkp_idx} < NBKP);

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
        end
    end

    always @* begin
        rd_d = 32'h00000000;
        case (i_avs_address)
            `RTCTO_OFF_TIME: rd_d = time_q;
            `RTCTO_OFF_DATE: rd_d = date_q;
            `RTCTO_OFF_CTL:  rd_d = ctl_q;
            `RTCTO_OFF_TAMP: rd_d = tcfg_q;
            `RTCTO_OFF_STAT: rd_d = {16'h0000, tflag_q[1], tflag_q[0], 2'h0, tsf_q, 2'h0,
                                     i_alarm_zero_flag, init_q, 7'h00};
            `RTCTO_OFF_PSC:  rd_d = psc_q;
            default: begin
                if (bkp_hit) begin
                    rd_d = bkp_q[bkp_idx];
                end
            end
        endcase
    end

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            rdata_q <= 32'h00000000;
        end else if (i_avs_read & ~ack_q) begin
            rdata_q <= rd_d;
        end
    end

    // Init state is system-domain; it guards calendar writes
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            init_q <= 1'b0;
        end else if (wr_go && i_avs_address == `RTCTO_OFF_STAT && i_avs_byteenable[0]) begin
            init_q <= i_avs_writedata[`RTCTO_ST_INIT];
        end
    end

    // Calendar registers hold written BCD fields only
    always @(posedge i_clk) begin
        if (!i_bkp_rst_n) begin
            time_q <= `RTCTO_TIME_RST;
            date_q <= `RTCTO_DATE_RST;
        end else if (!i_rst_n) begin
            if (!ctl_q[`RTCTO_CTL_BYPASS]) begin
                time_q <= `RTCTO_TIME_RST;
                date_q <= `RTCTO_DATE_RST;
            end
        end else if (wr_go && init_q && word_acc) begin
            if (i_avs_address == `RTCTO_OFF_TIME) begin
                time_q <= i_avs_writedata & `RTCTO_TIME_MASK;
            end
            if (i_avs_address == `RTCTO_OFF_DATE) begin
                date_q <= i_avs_writedata & `RTCTO_DATE_MASK;
            end
        end
    end

    // Configuration lives in the backup domain
    always @(posedge i_clk) begin
        if (!i_bkp_rst_n) begin
            ctl_q  <= 32'h00000000;
            tcfg_q <= 32'h00000000;
            psc_q  <= `RTCTO_PSC_RST;
        end else if (wr_go) begin
            if (i_avs_address == `RTCTO_OFF_CTL) begin
                ctl_q <= rtcto_merge(ctl_q, i_avs_writedata, i_avs_byteenable)
                         & `RTCTO_CTL_MASK;
            end
            if (i_avs_address == `RTCTO_OFF_TAMP) begin
                tcfg_q <= rtcto_merge(tcfg_q, i_avs_writedata, i_avs_byteenable)
                          & `RTCTO_TAMP_MASK;
            end
            // Prescalers only change in init so the divider stays coherent
            if (i_avs_address == `RTCTO_OFF_PSC && init_q) begin
                psc_q <= rtcto_merge(psc_q, i_avs_writedata, i_avs_byteenable)
                         & `RTCTO_PSC_MASK;
            end
        end
    end

    // Prescaler chain: async count down, then sync count down
    assign apre_tick = (apre_cnt_q == 7'h00);

    always @(posedge i_clk) begin
        if (!i_bkp_rst_n) begin
            apre_cnt_q <= 7'h7F;
            spre_cnt_q <= 15'h00FF;
        end else begin
            if (apre_tick) begin
                apre_cnt_q <= psc_q[`RTCTO_PSC_A_HI:`RTCTO_PSC_A_LO];
                if (spre_cnt_q == 15'h0000) begin
                    spre_cnt_q <= psc_q[`RTCTO_PSC_S_HI:0];
                end else begin
                    spre_cnt_q <= spre_cnt_q - 15'h0001;
                end
            end else begin
                apre_cnt_q <= apre_cnt_q - 7'h01;
            end
        end
    end

    // Calibration and alarm pins are registered to keep them glitch free
    always @(posedge i_clk) begin
        if (!i_bkp_rst_n) begin
            calib_q <= 1'b0;
            alarm_q <= 1'b0;
        end else begin
            if (!ctl_q[`RTCTO_CTL_CALEN]) begin
                calib_q <= 1'b0;
            end else if (ctl_q[`RTCTO_CTL_COS]) begin
                calib_q <= (spre_cnt_q > (psc_q[`RTCTO_PSC_S_HI:0] >> 1));
            end else begin
                calib_q <= apre_cnt_q[5];
            end
            alarm_q <= (|ctl_q[`RTCTO_CTL_SRC_HI:`RTCTO_CTL_SRC_LO])
                       & (i_alarm_zero_flag ^ ctl_q[`RTCTO_CTL_APOL]);
        end
    end

    assign o_calib_out = calib_q;
    assign o_calib_oe  = ctl_q[`RTCTO_CTL_CALEN];
    assign o_alarm_out = alarm_q;
    assign o_alarm_oe  = |ctl_q[`RTCTO_CTL_SRC_HI:`RTCTO_CTL_SRC_LO];

    // Level-mode sampling shared by both inputs
    assign filt = tcfg_q[`RTCTO_TP_FILT_HI:`RTCTO_TP_FILT_LO];
    assign rate = tcfg_q[`RTCTO_TP_RATE_HI:`RTCTO_TP_RATE_LO];
    assign pchg = tcfg_q[`RTCTO_TP_PCHG_HI:`RTCTO_TP_PCHG_LO];
    assign level_mode = (filt != 2'h0);
    assign need = 4'h1 << filt;
    assign samp_due = apre_tick && ((samp_cnt_q & (8'hFF >> rate)) == 8'h00);
    assign samp_strobe = (pch_q == 4'h1);

    always @(posedge i_clk) begin
        if (!i_bkp_rst_n) begin
            samp_cnt_q <= 8'h00;
            pch_q      <= 4'h0;
        end else begin
            if (apre_tick) begin
                samp_cnt_q <= samp_cnt_q + 8'h01;
            end
            if (samp_due && level_mode) begin
                pch_q <= 4'h1 << pchg;
            end else if (pch_q != 4'h0) begin
                pch_q <= pch_q - 4'h1;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_tamp
            localparam EN_B = `RTCTO_TP_EN0 + `RTCTO_TP_STRIDE * g;
            localparam EG_B = `RTCTO_TP_EG0 + `RTCTO_TP_STRIDE * g;
            reg        sync1_q;
            reg        sync2_q;
            reg        prev_q;
            reg  [3:0] lcnt_q;
            wire       en = tcfg_q[EN_B];
            wire       eg = tcfg_q[EG_B];
            wire       act = sync2_q ^ eg;
            wire       edge_ev;
            wire       lvl_ev;

            always @(posedge i_clk) begin
                if (!i_bkp_rst_n) begin
                    sync1_q <= 1'b0;
                    sync2_q <= 1'b0;
                    prev_q  <= 1'b0;
                end else begin
                    sync1_q <= i_tamper_pin[g];
                    sync2_q <= sync1_q;
                    prev_q  <= sync2_q;
                end
            end

            assign edge_ev = en && !level_mode
                             && (eg ? (prev_q & ~sync2_q) : (~prev_q & sync2_q));

            always @(posedge i_clk) begin
                if (!i_bkp_rst_n) begin
                    lcnt_q <= 4'h0;
                end else if (!en || !level_mode) begin
                    lcnt_q <= 4'h0;
                end else if (samp_strobe) begin
                    if (!act) begin
                        lcnt_q <= 4'h0;
                    end else if (lcnt_q != need) begin
                        lcnt_q <= lcnt_q + 4'h1;
                    end
                end
            end

            assign lvl_ev = en && level_mode && samp_strobe && act
                            && (lcnt_q + 4'h1 == need);
            assign ev[g] = edge_ev | lvl_ev;

            assign o_tamper_pullup[g] = en && level_mode && !tcfg_q[`RTCTO_TP_NOPU]
                                        && (pch_q != 4'h0);
        end
    endgenerate

    // Flags: writing 0 clears, a same-cycle event wins
    always @(posedge i_clk) begin
        if (!i_bkp_rst_n) begin
            tflag_q   <= 2'h0;
            tsf_q     <= 1'b0;
            ts_pend_q <= 2'h0;
        end else begin
            if (wr_go && i_avs_address == `RTCTO_OFF_STAT && i_avs_byteenable[1]) begin
                tflag_q <= (tflag_q & i_avs_writedata[`RTCTO_ST_TPF0+1:`RTCTO_ST_TPF0]) | ev;
                tsf_q   <= (tsf_q & i_avs_writedata[`RTCTO_ST_TSFLAG])
                           | (apre_tick & ts_pend_q[1]);
            end else begin
                tflag_q <= tflag_q | ev;
                tsf_q   <= tsf_q | (apre_tick & ts_pend_q[1]);
            end
            ts_pend_q[0] <= (apre_tick ? 1'b0 : ts_pend_q[0])
                            | ((|ev) & tcfg_q[`RTCTO_TP_TS]);
            if (apre_tick) begin
                ts_pend_q[1] <= ts_pend_q[0];
            end
        end
    end

    // Backup registers: tamper clear beats a same-cycle write
    always @(posedge i_clk) begin
        if (!i_bkp_rst_n || (|ev)) begin
            for (i = 0; i < NBKP; i = i + 1) begin
                bkp_q[i] <= 32'h00000000;
            end
        end else if (wr_go && bkp_hit) begin
            bkp_q[bkp_idx] <= rtcto_merge(bkp_q[bkp_idx], i_avs_writedata,
                                          i_avs_byteenable);
        end
    end

    assign o_tamper_irq    = tcfg_q[`RTCTO_TP_IE] & (|tflag_q);
    assign o_timestamp_irq = ctl_q[`RTCTO_CTL_TSINT] & tsf_q;
    assign o_alarm_irq     = ctl_q[`RTCTO_CTL_ALIE] & i_alarm_zero_flag;
    assign o_wakeup = i_slow_clk_src & (o_tamper_irq | o_timestamp_irq | o_alarm_irq);

endmodule

// *** rtcto_asserts.sv ***
`timescale 1ns/10ps
module rtcto_asserts #(
    parameter NBKP = 5
) (
    // Clock, resets and bus handshake
    input wire        i_clk,
    input wire        i_rst_n,
    input wire        i_bkp_rst_n,
    input wire        i_avs_read,
    input wire        i_avs_write,
    input wire [31:0] o_avs_readdata,
    input wire        o_avs_waitrequest,
    // Pins and events
    input wire [1:0]  i_tamper_pin,
    input wire [1:0]  o_tamper_pullup,
    input wire        i_alarm_zero_flag,
    input wire        i_slow_clk_src,
    input wire        o_calib_out,
    input wire        o_calib_oe,
    input wire        o_alarm_out,
    input wire        o_alarm_oe,
    input wire        o_tamper_irq,
    input wire        o_wakeup
);
    default clocking dc @(posedge i_clk); endclocking
    default disable iff (!i_rst_n || !i_bkp_rst_n);

    // Longest precharge is 8 clocks, so a longer run means a stuck pull-up
    logic [3:0] pu_run_q;
    always @(posedge i_clk) begin
        if (!i_bkp_rst_n || !o_tamper_pullup[0]) begin
            pu_run_q <= 4'h0;
        end else if (pu_run_q != 4'hF) begin
            pu_run_q <= pu_run_q + 4'h1;
        end
    end

    chk_wait_one: assert property (
        (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("request not answered after one wait cycle");
    chk_wait_idle: assert property (
        !(i_avs_read || i_avs_write) |=> o_avs_waitrequest)
        else $error("answer without a request");
    chk_rdata_hold: assert property (
        !i_avs_read |=> $stable(o_avs_readdata))
        else $error("read data moved without a read");
    chk_calib_gate: assert property (
        !o_calib_oe ##1 !o_calib_oe |-> !o_calib_out)
        else $error("calibration clock while disabled");
    chk_alarm_follow: assert property (
        o_alarm_oe && $past(o_alarm_oe) && $changed(i_alarm_zero_flag)
        |=> $changed(o_alarm_out))
        else $error("alarm pin missed a flag change");
    chk_pullup_short: assert property (
        pu_run_q <= 4'h8)
        else $error("pull-up held past longest precharge");
    chk_wake_slow: assert property (
        !i_slow_clk_src ##1 !i_slow_clk_src |-> !o_wakeup)
        else $error("wake-up on fast clock source");
    chk_sync_delay: assert property (
        $changed(i_tamper_pin) |=> !$rose(o_tamper_irq))
        else $error("tamper seen before synchronisation");
endmodule

bind rtcto_top rtcto_asserts #(.NBKP(NBKP)) asserts_u (
    .i_clk, .i_rst_n, .i_bkp_rst_n, .i_avs_read, .i_avs_write, .o_avs_readdata,
    .o_avs_waitrequest, .i_tamper_pin, .o_tamper_pullup, .i_alarm_zero_flag,
    .i_slow_clk_src, .o_calib_out, .o_calib_oe, .o_alarm_out, .o_alarm_oe,
    .o_tamper_irq, .o_wakeup
);

// *** rtcto_partner.sv ***
`timescale 1ns/10ps
module rtcto_partner (
    // Switch side
    input  wire        i_clk,
    input  wire [1:0]  i_drive,
    input  wire [1:0]  i_level,
    input  wire [1:0]  i_pullup,
    output wire [1:0]  o_pin,
    // Event controller side
    input  wire        i_irq,
    output wire [31:0] o_irq_count
);
    logic [1:0]  float_q = 2'h0;
    logic        irq_q = 1'b0;
    logic [31:0] cnt_q = 32'h0;

    // An open, unpulled pin wanders so no stale level can be trusted
    always @(posedge i_clk) begin
        float_q <= ~float_q;
        irq_q <= i_irq;
        if (i_irq && !irq_q) begin
            cnt_q <= cnt_q + 32'h1;
        end
    end

    assign o_pin = (i_drive & i_level) | (~i_drive & (i_pullup | float_q));
    assign o_irq_count = cnt_q;
endmodule

// *** testbench.sv ***
`timescale 1ns/10ps
module testbench;
    logic        i_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        i_bkp_rst_n = 1'b0;
    logic [5:0]  i_avs_address = 6'h00;
    logic        i_avs_read = 1'b0;
    logic        i_avs_write = 1'b0;
    logic [3:0]  i_avs_byteenable = 4'hF;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [1:0]  drv = 2'h3;
    logic [1:0]  lvl = 2'h2;
    logic        i_alarm_zero_flag = 1'b0;
    logic        i_slow_clk_src = 1'b1;
    wire  [31:0] o_avs_readdata;
    wire  [31:0] irq_count;
    wire  [1:0]  i_tamper_pin;
    wire  [1:0]  o_tamper_pullup;
    wire         o_avs_waitrequest, o_calib_out, o_calib_oe, o_alarm_out, o_alarm_oe;
    wire         o_tamper_irq, o_timestamp_irq, o_alarm_irq, o_wakeup;
    int          bad_count = 0;
    int          cmp_count = 0;
    int          cyc = 0;

    rtcto_partner partner_u (
        .i_clk, .i_drive(drv), .i_level(lvl), .i_pullup(o_tamper_pullup),
        .o_pin(i_tamper_pin), .i_irq(o_tamper_irq), .o_irq_count(irq_count)
    );
    rtcto_top #(.NBKP(5)) dut_u (
        .i_clk, .i_rst_n, .i_bkp_rst_n, .i_avs_address, .i_avs_read, .i_avs_write,
        .i_avs_byteenable, .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest,
        .i_tamper_pin, .o_tamper_pullup, .i_alarm_zero_flag, .i_slow_clk_src,
        .o_calib_out, .o_calib_oe, .o_alarm_out, .o_alarm_oe, .o_tamper_irq,
        .o_timestamp_irq, .o_alarm_irq, .o_wakeup
    );

    always #5 i_clk = ~i_clk;

    task automatic wrap_up;
        $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            wrap_up;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic nw(input int k);
        repeat (k) @(posedge i_clk);
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] b = 4'hF);
        @(posedge i_clk);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_byteenable <= b;
        i_avs_write <= 1'b1;
        do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
        i_avs_write <= 1'b0;
    endtask

    task automatic rc(input logic [5:0] a, input logic [31:0] exp);
        @(posedge i_clk);
        i_avs_address <= a;
        i_avs_read <= 1'b1;
        do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
        chk(o_avs_readdata, exp);
        i_avs_read <= 1'b0;
    endtask

    task automatic sys_rst;
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        nw(2);
        i_rst_n <= 1'b1;
    endtask

    task automatic t_regs;
        wr(6'h20, 32'hA5A5C3C3);
        wr(6'h00, 32'h00123456);
        rc(6'h00, 32'h0);
        rc(6'h04, 32'h00002101);
        rc(6'h18, 32'h0);
        wr(6'h10, 32'h80);
        wr(6'h00, 32'h00523456, 4'h7);
        rc(6'h00, 32'h0);
        wr(6'h00, 32'hFFFFFFFF);
        rc(6'h00, 32'h007F7F7F);
        wr(6'h00, 32'h00523456);
        wr(6'h04, 32'h0099F231);
        rc(6'h04, 32'h0099F231);
        wr(6'h08, 32'h20);
        sys_rst;
        rc(6'h00, 32'h00523456);
        rc(6'h04, 32'h0099F231);
        wr(6'h08, 32'h0);
        sys_rst;
        rc(6'h00, 32'h0);
        rc(6'h04, 32'h00002101);
        rc(6'h20, 32'hA5A5C3C3);
        $display("registers done");
    endtask

    task automatic t_tamper(input int idx);
        logic [31:0] cfg;
        int n;
        int c0;
        cfg = idx ? 32'h94 : 32'h84;
        wr(6'h08, 32'h00008000);
        wr(6'h20, 32'hA5A5C3C3);
        wr(6'h10, 32'h0);
        wr(6'h0C, cfg);
        c0 = irq_count;
        lvl[idx] <= ~lvl[idx];
        nw(12);
        chk(o_tamper_irq, 1'b0);
        lvl[idx] <= ~lvl[idx];
        nw(6);
        wr(6'h0C, cfg | (idx ? 32'h8 : 32'h1));
        nw(1);
        chk(o_tamper_pullup, 2'h0);
        lvl[idx] <= ~lvl[idx];
        for (n = 0; n < 20 && o_tamper_irq !== 1'b1; n++) @(posedge i_clk);
        chk(o_tamper_irq, 1'b1);
        chk(o_timestamp_irq, 1'b0);
        chk(o_wakeup, 1'b1);
        rc(6'h20, 32'h0);
        for (n = 0; n < 400 && o_timestamp_irq !== 1'b1; n++) @(posedge i_clk);
        chk(o_timestamp_irq, 1'b1);
        rc(6'h10, idx ? 32'h8800 : 32'h4800);
        chk(irq_count - c0, 1);
        i_slow_clk_src <= 1'b0;
        nw(3);
        chk(o_wakeup, 1'b0);
        i_slow_clk_src <= 1'b1;
        wr(6'h0C, 32'h0);
        lvl[idx] <= ~lvl[idx];
        wr(6'h10, 32'h0);
        $display("tamper %0d done", idx);
    endtask

    task automatic t_level;
        int n;
        int w;
        wr(6'h0C, 32'h6F04);
        wr(6'h0C, 32'h6F05);
        for (n = 0; n < 600 && o_tamper_pullup[0] !== 1'b1; n++) @(posedge i_clk);
        for (w = 0; o_tamper_pullup[0] === 1'b1; w++) @(posedge i_clk);
        chk(w, 8);
        lvl[0] <= 1'b1;
        for (n = w; o_tamper_pullup[0] !== 1'b1; n++) @(posedge i_clk);
        chk(n, 256);
        nw(200);
        chk(o_tamper_irq, 1'b0);
        for (n = 0; n < 100 && o_tamper_irq !== 1'b1; n++) @(posedge i_clk);
        chk(o_tamper_irq, 1'b1);
        wr(6'h0C, 32'hEF05);
        for (n = 0; n < 300 && o_tamper_pullup[0] !== 1'b1; n++) @(posedge i_clk);
        chk(o_tamper_pullup[0], 1'b0);
        chk(o_timestamp_irq, 1'b0);
        wr(6'h0C, 32'h0);
        wr(6'h10, 32'h0);
        // Open pin: only the precharge pull-up makes it read active
        drv[0] <= 1'b0;
        wr(6'h0C, 32'h7F04);
        wr(6'h0C, 32'h7F05);
        nw(1700);
        chk(o_tamper_irq, 1'b0);
        for (n = 0; n < 400 && o_tamper_irq !== 1'b1; n++) @(posedge i_clk);
        chk(o_tamper_irq, 1'b1);
        wr(6'h0C, 32'h0);
        drv[0] <= 1'b1;
        lvl[0] <= 1'b0;
        wr(6'h10, 32'h0);
        $display("level mode done");
    endtask

    task automatic t_alarm;
        wr(6'h08, 32'h00200000);
        i_alarm_zero_flag <= 1'b1;
        nw(3);
        chk(o_alarm_oe, 1'b1);
        chk(o_alarm_out, 1'b1);
        wr(6'h08, 32'h00301000);
        nw(3);
        chk(o_alarm_out, 1'b0);
        chk(o_alarm_irq, 1'b1);
        chk(o_wakeup, 1'b1);
        i_alarm_zero_flag <= 1'b0;
        nw(3);
        chk(o_alarm_out, 1'b1);
        chk(o_alarm_irq, 1'b0);
        wr(6'h08, 32'h0);
        nw(2);
        chk(o_alarm_oe, 1'b0);
        $display("alarm output done");
    endtask

    // First call may start mid-cycle; the second always sees a whole period
    task automatic period(output int p);
        while (o_calib_out !== 1'b1) @(posedge i_clk);
        p = 0;
        while (o_calib_out !== 1'b0) begin
            @(posedge i_clk);
            p++;
        end
        while (o_calib_out !== 1'b1) begin
            @(posedge i_clk);
            p++;
        end
    endtask

    task automatic t_calib;
        int p;
        wr(6'h08, 32'h00800000);
        nw(1);
        chk(o_calib_oe, 1'b1);
        period(p);
        period(p);
        chk(p, 64);
        wr(6'h10, 32'h80);
        wr(6'h14, 32'h00010003);
        wr(6'h10, 32'h0);
        wr(6'h08, 32'h00880000);
        period(p);
        period(p);
        chk(p, 8);
        wr(6'h08, 32'h0);
        nw(3);
        chk(o_calib_out, 1'b0);
        $display("calibration output done");
    endtask

    initial begin
        nw(2);
        i_rst_n <= 1'b1;
        i_bkp_rst_n <= 1'b1;
        t_regs;
        t_tamper(0);
        t_tamper(1);
        t_level;
        t_alarm;
        t_calib;
        wrap_up;
    end
endmodule
